// [rtl/ssbsr_group.v]
// One status group: transition filters, sticky event register, summary
`timescale 1ns/100ps
module ssbsr_group #(
  parameter W = 16
) (
  input wire clk,
  input wire nrst,
  input wire [W-1:0] cond,
  input wire [W-1:0] ptr,
  input wire [W-1:0] ntr,
  input wire [W-1:0] enab,
  input wire evt_rd,
  input wire evt_clr,
  output reg [W-1:0] event_r,
  output wire summary
);
  reg [W-1:0] cond_r;
  genvar i;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cond_r <= {W{1'b0}};
    else
      cond_r <= cond;
  end

  // ------------------------------------------------------------
  // Event bits, set wins over read-clear
  // ------------------------------------------------------------
  generate
    for (i = 0; i < W; i = i + 1)
    begin : g_bit
      wire hit;
      assign hit = (ptr[i] & cond[i] & ~cond_r[i]) |
                   (ntr[i] & ~cond[i] & cond_r[i]);
      always @(posedge clk or negedge nrst)
      begin
        if (!nrst)
          event_r[i] <= 1'b0;
        else if (hit)
          event_r[i] <= 1'b1;
        else if (evt_rd | evt_clr)
          event_r[i] <= 1'b0;
      end
    end
  endgenerate

  assign summary = |(event_r & enab);
endmodule

// [rtl/ssbsr_regs.vh]
// Constants for the status byte and service request block
`ifndef SSBSR_REGS_VH
`define SSBSR_REGS_VH
`define SSBSR_BIT_QUES 3
`define SSBSR_BIT_MAV 4
`define SSBSR_BIT_ESB 5
`define SSBSR_BIT_RQS 6
`define SSBSR_BIT_OPER 7
`define SSBSR_ESR_ERR_LO 2
`define SSBSR_ESR_ERR_HI 5
`define SSBSR_PTR_RESET 16'hFFFF
`define SSBSR_NTR_RESET 16'h0000
`define SSBSR_MASK_RESET 16'h0000
`define SSBSR_SRE_RESET 8'h00
`define SSBSR_ESE_RESET 8'h00
`endif

// [rtl/ssbsr_top.v]
// Status byte, group summaries and service request line
//
// Notes on behaviour
// - Status byte bit 4 set while output queue holds a message.
// - Bit 5 summarises standard events; event query returns logged bits.
// - Reading the standard event register clears it.
// - Standard event bits 2 to 5 are error-class events.
// - Any set error bit implies an error queue entry exists; code only flags a missing entry on err_queue_fault.
// - Bit 7 summarises operation group; its event query returns bits.
// - Reading the operation event register clears its bits, except any set in the same cycle.
// - Writing zero to standard event enable clears it.
// - Writing zero to status byte enable clears it; no request.
// - Preset clears operation and questionable enable masks.
// - Masked status byte summary drives the request-service bit.
// - Serial poll releases the asserted service request line.
// - Status byte query leaves request-service bit unchanged.
// - Group enable mask selects which events feed its summary.
// - Power-on: positive filters all ones, negative filters zero.
// - Bit 3 summarises questionable group; its events clear on read.
`timescale 1ns/100ps
`include "ssbsr_regs.vh"
module ssbsr_top #(
  parameter W = 16
) (
  input wire clk,
  input wire nrst,
  input wire msg_avail,
  input wire [7:0] std_evt_set,
  input wire err_queue_nonempty,
  input wire [W-1:0] oper_cond,
  input wire [W-1:0] ques_cond,
  input wire esr_rd,
  input wire oper_evt_rd,
  input wire ques_evt_rd,
  input wire clear_status,
  input wire ese_wr,
  input wire [7:0] ese_wdata,
  input wire sre_wr,
  input wire [7:0] sre_wdata,
  input wire oper_enab_wr,
  input wire ques_enab_wr,
  input wire [W-1:0] enab_wdata,
  input wire oper_ptr_wr,
  input wire oper_ntr_wr,
  input wire ques_ptr_wr,
  input wire ques_ntr_wr,
  input wire [W-1:0] tr_wdata,
  input wire preset,
  input wire serial_poll,
  output reg [7:0] status_summary_byte,
  output reg [7:0] esr_r,
  output wire [W-1:0] oper_event,
  output wire [W-1:0] ques_event,
  output reg [7:0] ese_r,
  output reg [7:0] sre_r,
  output reg [W-1:0] oper_enab_r,
  output reg [W-1:0] ques_enab_r,
  output reg srq_n_out,
  output reg srq_n_oe,
  output wire err_class_event,
  output reg err_queue_fault
);
  reg [W-1:0] oper_ptr_r;
  reg [W-1:0] oper_ntr_r;
  reg [W-1:0] ques_ptr_r;
  reg [W-1:0] ques_ntr_r;
  reg srq_active_r;
  reg rqs_prev_r;
  wire operation_summary_bit;
  wire ques_summary;
  wire esb_summary;
  wire [7:0] stb_nxt;
  wire rqs;

  // ------------------------------------------------------------
  // Operation and questionable groups
  // ------------------------------------------------------------
  ssbsr_group #(.W(W)) u_oper (
    .clk(clk),
    .nrst(nrst),
    .cond(oper_cond),
    .ptr(oper_ptr_r),
    .ntr(oper_ntr_r),
    .enab(oper_enab_r),
    .evt_rd(oper_evt_rd),
    .evt_clr(clear_status),
    .event_r(oper_event),
    .summary(operation_summary_bit)
  );

  ssbsr_group #(.W(W)) u_ques (
    .clk(clk),
    .nrst(nrst),
    .cond(ques_cond),
    .ptr(ques_ptr_r),
    .ntr(ques_ntr_r),
    .enab(ques_enab_r),
    .evt_rd(ques_evt_rd),
    .evt_clr(clear_status),
    .event_r(ques_event),
    .summary(ques_summary)
  );

  // ------------------------------------------------------------
  // Filters and enable masks
  // ------------------------------------------------------------
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      oper_ptr_r <= `SSBSR_PTR_RESET;
      ques_ptr_r <= `SSBSR_PTR_RESET;
      oper_ntr_r <= `SSBSR_NTR_RESET;
      ques_ntr_r <= `SSBSR_NTR_RESET;
      oper_enab_r <= `SSBSR_MASK_RESET;
      ques_enab_r <= `SSBSR_MASK_RESET;
      ese_r <= `SSBSR_ESE_RESET;
      sre_r <= `SSBSR_SRE_RESET;
    end
    else
    begin
      if (oper_ptr_wr)
        oper_ptr_r <= tr_wdata;
      if (oper_ntr_wr)
        oper_ntr_r <= tr_wdata;
      if (ques_ptr_wr)
        ques_ptr_r <= tr_wdata;
      if (ques_ntr_wr)
        ques_ntr_r <= tr_wdata;
      // Preset overrides a same-cycle enable write
      if (preset)
        oper_enab_r <= `SSBSR_MASK_RESET;
      else if (oper_enab_wr)
        oper_enab_r <= enab_wdata;
      if (preset)
        ques_enab_r <= `SSBSR_MASK_RESET;
      else if (ques_enab_wr)
        ques_enab_r <= enab_wdata;
      if (ese_wr)
        ese_r <= ese_wdata;
      if (sre_wr)
        sre_r <= sre_wdata;
    end
  end

  // ------------------------------------------------------------
  // Standard event register, set wins over read-clear
  // ------------------------------------------------------------
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      esr_r <= 8'h00;
    else if (esr_rd | clear_status)
      esr_r <= std_evt_set;
    else
      esr_r <= esr_r | std_evt_set;
  end

  assign err_class_event =
    |esr_r[`SSBSR_ESR_ERR_HI:`SSBSR_ESR_ERR_LO];

  // Error bit logged without a queue entry; source must keep queue in step
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      err_queue_fault <= 1'b0;
    else
      err_queue_fault <= err_class_event & ~err_queue_nonempty;
  end

  // ------------------------------------------------------------
  // Status byte and request service
  // ------------------------------------------------------------
  assign esb_summary = |(esr_r & ese_r);

  // Bit 6 excluded from the mask so the request cannot hold itself up
  assign stb_nxt = {operation_summary_bit, 1'b0, esb_summary,
                    msg_avail, ques_summary, 3'b000};
  assign rqs = |(stb_nxt & sre_r & 8'hBF);

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      status_summary_byte <= 8'h00;
      rqs_prev_r <= 1'b0;
      srq_active_r <= 1'b0;
      srq_n_out <= 1'b1;
      srq_n_oe <= 1'b1;
    end
    else
    begin
      // Status byte reads have no side effect on the request bit
      status_summary_byte <= stb_nxt | {1'b0, rqs, 6'h00};
      rqs_prev_r <= rqs;
      if (serial_poll)
        srq_active_r <= 1'b0;
      else if (rqs & ~rqs_prev_r)
        srq_active_r <= 1'b1;
      else if (!rqs)
        srq_active_r <= 1'b0;
      srq_n_out <= 1'b0;
      srq_n_oe <= ~(srq_active_r & ~serial_poll);
    end
  end
endmodule

// [test/ssbsr_host.sv]
// Bus controller model that serial-polls on a service request
`timescale 1ns/100ps
module ssbsr_host (
  input wire clk,
  input wire nrst,
  input wire srq_n_out,
  input wire srq_n_oe,
  input wire slow,
  output logic serial_poll
);
  // Line has a pull-up, so a released line reads high
  wire srq_line = srq_n_oe ? 1'b1 : srq_n_out;
  integer cnt = 0;
  initial serial_poll = 1'b0;
  always @(negedge clk)
  begin
    serial_poll <= 1'b0;
    if (!nrst || srq_line)
      cnt <= 0;
    else if (cnt == (slow ? 8 : 0) && !serial_poll)
      serial_poll <= 1'b1;
    else
      cnt <= cnt + 1;
  end
endmodule

// [test/ssbsr_top_properties.sv]
// Checker for the status byte and service request block
`timescale 1ns/100ps
module ssbsr_props #(
  parameter W = 16
) (
  input wire clk,
  input wire nrst,
  input wire msg_avail,
  input wire [7:0] std_evt_set,
  input wire esr_rd,
  input wire preset,
  input wire serial_poll,
  input wire [7:0] status_summary_byte,
  input wire [7:0] esr_r,
  input wire [7:0] ese_r,
  input wire [7:0] sre_r,
  input wire [W-1:0] oper_event,
  input wire [W-1:0] oper_enab_r,
  input wire [W-1:0] ques_enab_r,
  input wire srq_n_oe,
  input wire err_class_event
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire [7:0] sb = status_summary_byte;
  sequence rqs_rise;
    $rose(sb[6]) && !serial_poll;
  endsequence
  a_msg_bit: assert property ($past(nrst) |-> sb[4] == $past(msg_avail))
    else $error("message bit wrong");
  a_esb_sum: assert property ($past(nrst) |->
    sb[5] == |($past(esr_r) & $past(ese_r))) else $error("esb wrong");
  a_opr_sum: assert property ($past(nrst) |->
    sb[7] == |($past(oper_event) & $past(oper_enab_r)))
    else $error("opr wrong");
  a_rqs_feed: assert property ($past(nrst) |->
    sb[6] == |(sb & $past(sre_r) & 8'hBF)) else $error("rqs wrong");
  a_srq_raise: assert property (rqs_rise |=> !srq_n_oe)
    else $error("srq not driven");
  a_poll_rel: assert property (serial_poll |-> ##[1:2] srq_n_oe)
    else $error("srq not released");
  a_esr_clr: assert property (esr_rd |=> esr_r == $past(std_evt_set))
    else $error("esr not cleared");
  a_preset_clr: assert property (preset |=> oper_enab_r == 0 &&
    ques_enab_r == 0) else $error("preset failed");
  a_err_class: assert property (err_class_event == |esr_r[5:2])
    else $error("error class wrong");
endmodule
bind ssbsr_top ssbsr_props #(.W(W)) props_u (.*);

// [test/status_byte_service_request_tb.sv]
// Testbench for the status byte and service request block
`timescale 1ns/100ps
module status_byte_service_request_tb;
  logic clk = 0, nrst = 0, msg_avail = 0, err_queue_nonempty = 0;
  logic esr_rd = 0, oper_evt_rd = 0, ques_evt_rd = 0, clear_status = 0;
  logic ese_wr = 0, sre_wr = 0, oper_enab_wr = 0, ques_enab_wr = 0;
  logic oper_ptr_wr = 0, oper_ntr_wr = 0, ques_ptr_wr = 0;
  logic ques_ntr_wr = 0, preset = 0, slow = 0;
  logic [7:0] std_evt_set = 0, ese_wdata = 0, sre_wdata = 0;
  logic [15:0] oper_cond = 0, ques_cond = 0, enab_wdata = 0, tr_wdata = 0;
  wire serial_poll, srq_n_out, srq_n_oe, err_class_event, err_queue_fault;
  wire [7:0] status_summary_byte, esr_r, ese_r, sre_r;
  wire [15:0] oper_event, ques_event, oper_enab_r, ques_enab_r;
  integer mismatches = 0, checked = 0, i, e, m, x;
  ssbsr_top dut_u (.*);
  ssbsr_host host_u (.*);
  initial forever #10 clk = ~clk;
  task chk(input [31:0] got, input [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task end_of_test;
    if (mismatches == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task tick(input integer n);
    repeat (n) @(negedge clk);
  endtask
  initial
  begin
    #20000 mismatches++;
    end_of_test;
  end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    x = $urandom(22);
    tick(16);
    nrst = 1;
    err_queue_nonempty = 1;
    chk({srq_n_oe, status_summary_byte, sre_r, ese_r}, 25'h1000000);
    for (i = 0; i < 2; i++)
    begin
      slow = i;
      sre_wr = 1;
      sre_wdata = 8'h10;
      msg_avail = 1;
      tick(1);
      sre_wr = 0;
      tick(2);
      chk({srq_n_oe, srq_n_out, status_summary_byte}, 10'h050);
      for (x = 0; x < 20 && srq_n_oe !== 1'b1; x++) tick(1);
      tick(3);
      chk({srq_n_oe, status_summary_byte}, 9'h150);
      sre_wr = 1;
      sre_wdata = 8'h00;
      tick(1);
      sre_wr = 0;
      msg_avail = 0;
      tick(1);
      chk({sre_r, status_summary_byte[6]}, 9'h000);
    end
    for (i = 0; i < 6; i++)
    begin
      m = (i == 5) ? 0 : $urandom;
      e = $urandom;
      // Odd passes leave the error queue empty so the fault flag can fire
      err_queue_nonempty = ~i[0];
      ese_wr = 1;
      ese_wdata = m[7:0];
      std_evt_set = e[7:0];
      tick(1);
      ese_wr = 0;
      std_evt_set = 0;
      tick(1);
      chk(esr_r, e & 8'hFF);
      chk(ese_r, m & 8'hFF);
      chk(err_class_event, (e & 8'h3C) != 0);
      chk(err_queue_fault, ((e & 8'h3C) != 0) && i[0]);
      chk(status_summary_byte[5], (e & m & 8'hFF) != 0);
      esr_rd = 1;
      tick(1);
      esr_rd = 0;
      chk(esr_r, 0);
    end
    enab_wdata = 16'h0401;
    oper_enab_wr = 1;
    ques_enab_wr = 1;
    tick(1);
    oper_enab_wr = 0;
    ques_enab_wr = 0;
    for (i = 0; i < 4; i++)
    begin
      x = $urandom & 16'hFFFF;
      oper_cond = x[15:0];
      ques_cond = x[15:0];
      tick(3);
      chk({oper_event, ques_event}, {x[15:0], x[15:0]});
      chk(status_summary_byte & 8'h88, (x & 16'h0401) ? 8'h88 : 0);
      oper_evt_rd = 1;
      ques_evt_rd = 1;
      tick(1);
      oper_evt_rd = 0;
      ques_evt_rd = 0;
      oper_cond = 0;
      ques_cond = 0;
      tick(3);
      chk({oper_event, ques_event}, 0);
    end
    preset = 1;
    enab_wdata = 16'hFFFF;
    oper_enab_wr = 1;
    tick(1);
    preset = 0;
    oper_enab_wr = 0;
    chk({oper_enab_r, ques_enab_r}, 0);
    std_evt_set = 8'h04;
    tick(1);
    std_evt_set = 0;
    clear_status = 1;
    tick(1);
    clear_status = 0;
    chk(esr_r, 0);
    end_of_test;
  end
endmodule
